// ==== shared/ac_bridge_defs.vh ====
`ifndef AC_BRIDGE_DEFS_VH
`define AC_BRIDGE_DEFS_VH

// ---------------------------------------------------------------
// Timing counts in master clock cycles; the settling count is in word periods.
// ---------------------------------------------------------------
`define EXC_HALF_CYCLES 2048
`define SAMPLE_DELAY_CYCLES 64
`define WORD_PERIOD_CYCLES 81920
`define SETTLE_WORDS 6

// ---------------------------------------------------------------
// Field widths, reset values and calibration limits.
// ---------------------------------------------------------------
`define GAIN_W 2
`define TRIM_W 4
`define GAIN_RESET 2'h0
`define TRIM_RESET 4'h8
`define CAL_MIN_PCT 80
`define CAL_MAX_PCT 120
`define CAL_NOM_PCT 100
`define MOD_PCT_W 8

`endif

// ==== hw/word_fifo.v ====
`timescale 1ns/1ps
module word_fifo #(
  parameter WIDTH = 24,
  parameter DEPTH = 4,
  parameter AW = 2
) (
  input wire clk,
  input wire rst,
  input wire ce,
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output reg [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem_q [0:DEPTH-1];
  reg [AW-1:0] wr_q;
  reg [AW-1:0] rd_q;
  reg [AW:0] cnt_q;
  wire push;
  wire pop;
  integer i;

  assign in_ready = (cnt_q != DEPTH);
  assign out_valid = (cnt_q != 0);
  assign push = ce && in_valid && in_ready;
  assign pop = ce && out_valid && out_ready;

  always @* begin
    out_data = mem_q[rd_q];
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_q <= {AW{1'b0}};
      rd_q <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
      for (i = 0; i < DEPTH; i = i + 1) begin
        mem_q[i] <= {WIDTH{1'b0}};
      end
    end else begin
      if (push) begin
        mem_q[wr_q] <= in_data;
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop && !push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule

// ==== hw/ac_bridge_excitation_detect.v ====
// Functional notes
// - Internal mode divides master clock to excitation clock, driven on pin.
// - Detection multiplies samples by excitation phase, keeping in-phase content.
// - External mode takes the phase pin as input; its phase sets detection.
// - Samples are taken 64 master cycles after each internal edge, two more after an external pin edge.
// - Conversion words come out every 81920 cycles, 50 Hz at 4.096 MHz.
// - After each external polarity change, six word periods pass before settling.
// - Gain select 1, 2, 4 or 8 and a four-bit offset trim.
// - Gain calibration accepts spans within plus or minus 20 percent.
`timescale 1ns/1ps
`include "ac_bridge_defs.vh"
module ac_bridge_excitation_detect #(
  parameter SW = 16,
  parameter ACC_W = 24,
  parameter FIFO_DEPTH = 4,
  parameter FIFO_AW = 2,
  parameter WORD_PERIOD = `WORD_PERIOD_CYCLES,
  parameter EXC_HALF = `EXC_HALF_CYCLES
) (
  input wire CLOCK,
  input wire RST,
  input wire CE,
  input wire AC_MODE,
  input wire EXT_EXC,
  input wire [`GAIN_W-1:0] GAIN_SEL,
  input wire [`TRIM_W-1:0] OFFSET_TRIM,
  input wire [`MOD_PCT_W-1:0] SPAN_PCT,
  input wire [SW-1:0] SIGNAL_INPUT,
  input wire [SW-1:0] REF_INPUT,
  input wire EXCITATION_PHASE_PIN_IN,
  output wire EXCITATION_PHASE_PIN_OUT,
  output wire EXCITATION_PHASE_PIN_OE,
  output reg EXCITATION_OUT_PIN,
  output reg SAMPLE_STROBE,
  output wire DATA_READY_N,
  input wire WORD_READY,
  output wire [ACC_W-1:0] WORD_DATA,
  output wire [ACC_W-1:0] REF_WORD_DATA,
  output reg SETTLED,
  output reg CAL_OK,
  output reg OVERRUN
);
  // ---------------------------------------------------------------
  // Excitation source and phase-pin synchroniser.
  // ---------------------------------------------------------------
  reg [16:0] div_q;
  reg int_phase_q;
  reg ext_s1_q;
  reg ext_s2_q;
  reg ext_prev_q;
  wire phase;
  wire edge_ev;
  wire int_edge;

  assign int_edge = (div_q == EXC_HALF - 1);
  // Pin is driven only in internal mode; external mode listens.
  assign EXCITATION_PHASE_PIN_OE = AC_MODE && !EXT_EXC;
  assign EXCITATION_PHASE_PIN_OUT = int_phase_q;
  assign phase = EXT_EXC ? ext_s2_q : int_phase_q;
  assign edge_ev = AC_MODE &&
    (EXT_EXC ? (ext_s2_q != ext_prev_q) : int_edge);

  always @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      div_q <= 17'h00000;
      int_phase_q <= 1'b0;
      ext_s1_q <= 1'b0;
      ext_s2_q <= 1'b0;
      ext_prev_q <= 1'b0;
      EXCITATION_OUT_PIN <= 1'b0;
    end else if (CE) begin
      ext_s1_q <= EXCITATION_PHASE_PIN_IN;
      ext_s2_q <= ext_s1_q;
      ext_prev_q <= ext_s2_q;
      if (int_edge) begin
        div_q <= 17'h00000;
        int_phase_q <= !int_phase_q;
      end else begin
        div_q <= div_q + 17'h00001;
      end
      EXCITATION_OUT_PIN <= AC_MODE & phase;
    end
  end

  // ---------------------------------------------------------------
  // Sample delay after each switching edge.
  // ---------------------------------------------------------------
  reg [6:0] dly_q;
  reg dly_run_q;
  wire take;

  // Without ac mode every cycle is a dc sample.
  assign take = AC_MODE ? (dly_run_q &&
    dly_q == `SAMPLE_DELAY_CYCLES - 1) : 1'b1;

  always @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      dly_q <= 7'h00;
      dly_run_q <= 1'b0;
      SAMPLE_STROBE <= 1'b0;
    end else if (CE) begin
      SAMPLE_STROBE <= AC_MODE && take;
      if (edge_ev) begin
        // A new edge restarts the wait; the earlier sample is dropped.
        dly_q <= 7'h00;
        dly_run_q <= 1'b1;
      end else if (dly_run_q) begin
        if (take) begin
          dly_run_q <= 1'b0;
        end
        dly_q <= dly_q + 7'h01;
      end
    end
  end

  // ---------------------------------------------------------------
  // Gain, trim and synchronous accumulation.
  // ---------------------------------------------------------------
  function [ACC_W-1:0] scale;
    input [SW-1:0] v;
    input [`GAIN_W-1:0] g;
    input inv;
    reg [ACC_W-1:0] x;
    begin
      x = {{(ACC_W-SW){v[SW-1]}}, v} <<< g;
      scale = inv ? (~x + 1'b1) : x;
    end
  endfunction

  reg [ACC_W-1:0] acc_q;
  reg [ACC_W-1:0] racc_q;
  reg [16:0] word_q;
  wire word_end;
  wire [ACC_W-1:0] trim;
  wire fifo_ready;
  wire fifo_valid;
  wire [2*ACC_W-1:0] fifo_out;
  wire [`TRIM_W-1:0] trim_off;

  assign word_end = (word_q == WORD_PERIOD - 1);
  // Trim spans both signs around mid code, so the step is sign-extended.
  assign trim_off = OFFSET_TRIM - `TRIM_RESET;
  assign trim = {{(ACC_W-`TRIM_W){trim_off[`TRIM_W-1]}}, trim_off}
    << (ACC_W - 5);

  always @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      acc_q <= {ACC_W{1'b0}};
      racc_q <= {ACC_W{1'b0}};
      word_q <= 17'h00000;
      OVERRUN <= 1'b0;
    end else if (CE) begin
      if (word_end) begin
        word_q <= 17'h00000;
        acc_q <= {ACC_W{1'b0}};
        racc_q <= {ACC_W{1'b0}};
        // A full queue drops the word; the flag stays until reset.
        if (!fifo_ready) begin
          OVERRUN <= 1'b1;
        end
      end else begin
        word_q <= word_q + 17'h00001;
        if (take) begin
          acc_q <= acc_q + scale(SIGNAL_INPUT, GAIN_SEL,
            AC_MODE & !phase);
          racc_q <= racc_q + scale(REF_INPUT, 2'h0, AC_MODE & !phase);
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Settling count after external polarity changes.
  // ---------------------------------------------------------------
  reg [2:0] settle_q;

  always @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      settle_q <= 3'h0;
      SETTLED <= 1'b0;
    end else if (CE) begin
      if (edge_ev && EXT_EXC) begin
        settle_q <= 3'h0;
        SETTLED <= 1'b0;
      end else if (word_end && settle_q != `SETTLE_WORDS) begin
        settle_q <= settle_q + 3'h1;
        SETTLED <= (settle_q == `SETTLE_WORDS - 1);
      end
    end
  end

  // ---------------------------------------------------------------
  // Gain calibration window check.
  // ---------------------------------------------------------------
  always @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      CAL_OK <= 1'b0;
    end else if (CE) begin
      CAL_OK <= (SPAN_PCT >= `CAL_MIN_PCT) &&
        (SPAN_PCT <= `CAL_MAX_PCT);
    end
  end

  // ---------------------------------------------------------------
  // Output word queue; data ready is low while a word waits.
  // ---------------------------------------------------------------
  word_fifo #(
    .WIDTH(2*ACC_W),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) u_fifo (
    .clk(CLOCK),
    .rst(RST),
    .ce(CE),
    .in_valid(word_end),
    .in_ready(fifo_ready),
    .in_data({racc_q, acc_q + trim}),
    .out_valid(fifo_valid),
    .out_ready(WORD_READY),
    .out_data(fifo_out)
  );

  assign DATA_READY_N = !fifo_valid;
  assign WORD_DATA = fifo_out[ACC_W-1:0];
  assign REF_WORD_DATA = fifo_out[2*ACC_W-1:ACC_W];
endmodule

// ==== bench/ac_bridge_monitor.sv ====
`timescale 1ns/1ps
module ac_bridge_monitor (
  input wire CLOCK,
  input wire RST,
  input wire CE,
  input wire AC_MODE,
  input wire EXT_EXC,
  input wire [7:0] SPAN_PCT,
  input wire EXCITATION_PHASE_PIN_IN,
  input wire EXCITATION_PHASE_PIN_OE,
  input wire EXCITATION_OUT_PIN,
  input wire SAMPLE_STROBE,
  input wire DATA_READY_N,
  input wire WORD_READY,
  input wire SETTLED,
  input wire CAL_OK,
  input wire OVERRUN
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (RST);
  wire ext = CE && AC_MODE && EXT_EXC;
  wire int_mode = AC_MODE && !EXT_EXC;
  sequence s_flip;
    ext && $changed(EXCITATION_PHASE_PIN_IN);
  endsequence
  property p_oe;
    $stable(AC_MODE) && $stable(EXT_EXC) |->
      EXCITATION_PHASE_PIN_OE == int_mode;
  endproperty
  property p_dc;
    !AC_MODE |=> !EXCITATION_OUT_PIN;
  endproperty
  property p_half;
    int_mode && $changed(EXCITATION_OUT_PIN) |=>
      $stable(EXCITATION_OUT_PIN) [*8];
  endproperty
  property p_strobe;
    s_flip |-> ##[65:68] SAMPLE_STROBE;
  endproperty
  property p_settle;
    s_flip |-> ##5 !SETTLED [*8];
  endproperty
  property p_hold;
    !DATA_READY_N && !WORD_READY |=> !DATA_READY_N;
  endproperty
  property p_ovr;
    OVERRUN |=> OVERRUN;
  endproperty
  property p_cal;
    CE && $stable(SPAN_PCT) && !$past(RST) |->
      CAL_OK == (SPAN_PCT >= 8'h50 && SPAN_PCT <= 8'h78);
  endproperty
  a_oe: assert property (p_oe) else $error("pin enable wrong");
  a_dc: assert property (p_dc) else $error("drive in dc mode");
  a_half: assert property (p_half) else $error("short half");
  a_strobe: assert property (p_strobe) else $error("no sample");
  a_settle: assert property (p_settle) else $error("early settle");
  a_hold: assert property (p_hold) else $error("word lost");
  a_ovr: assert property (p_ovr) else $error("overrun cleared");
  a_cal: assert property (p_cal) else $error("cal flag wrong");
endmodule
bind ac_bridge_excitation_detect ac_bridge_monitor i_mon (
  .CLOCK(CLOCK), .RST(RST), .CE(CE), .AC_MODE(AC_MODE),
  .EXT_EXC(EXT_EXC), .SPAN_PCT(SPAN_PCT),
  .EXCITATION_PHASE_PIN_IN(EXCITATION_PHASE_PIN_IN),
  .EXCITATION_PHASE_PIN_OE(EXCITATION_PHASE_PIN_OE),
  .EXCITATION_OUT_PIN(EXCITATION_OUT_PIN),
  .SAMPLE_STROBE(SAMPLE_STROBE), .DATA_READY_N(DATA_READY_N),
  .WORD_READY(WORD_READY), .SETTLED(SETTLED), .CAL_OK(CAL_OK),
  .OVERRUN(OVERRUN));

// ==== bench/host_model.sv ====
`timescale 1ns/1ps
module host_model (
  input wire CLOCK,
  input wire DATA_READY_N,
  input wire stall,
  input wire flip_en,
  output reg WORD_READY,
  output reg phase,
  output integer words
);
  reg data_ready_n_n_q;
  initial begin
    WORD_READY = 0;
    phase = 0;
    words = 0;
    data_ready_n_n_q = 1;
  end
  // Phase moves only on a word fall, so each kept word sees one polarity.
  always @(negedge CLOCK) begin
    WORD_READY <= !stall;
    data_ready_n_n_q <= DATA_READY_N;
    if (data_ready_n_n_q && !DATA_READY_N) begin
      words <= words + 1;
      if (flip_en && words % 6 == 5) phase <= !phase;
    end
  end
endmodule

// ==== bench/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
  localparam WP = 200;
  localparam EH = 100;
  reg CLOCK = 0;
  reg RST = 1;
  reg AC_MODE = 1;
  reg EXT_EXC = 0;
  reg [1:0] GAIN_SEL = 2'h0;
  reg [7:0] SPAN_PCT = 8'h64;
  reg stall = 0;
  reg flip_en = 0;
  wire pin_out, pin_oe, exc_out, strobe, data_ready_n_n, ready, phase;
  wire settled, cal_ok, ovr;
  wire [23:0] word, ref_word;
  wire pin = pin_oe ? pin_out : phase;
  integer miscompares = 0;
  integer n_checks = 0;
  integer i, words;
  time t0;
  reg [10:0] rows [0:4];
  always #2 CLOCK = ~CLOCK;
  ac_bridge_excitation_detect #(.WORD_PERIOD(WP), .EXC_HALF(EH)) i_dut (
    .CLOCK(CLOCK), .RST(RST), .CE(1'b1), .AC_MODE(AC_MODE),
    .EXT_EXC(EXT_EXC), .GAIN_SEL(GAIN_SEL), .OFFSET_TRIM(4'h8),
    .SPAN_PCT(SPAN_PCT), .SIGNAL_INPUT(16'h0123), .REF_INPUT(16'h0456),
    .EXCITATION_PHASE_PIN_IN(pin), .EXCITATION_PHASE_PIN_OUT(pin_out),
    .EXCITATION_PHASE_PIN_OE(pin_oe), .EXCITATION_OUT_PIN(exc_out),
    .SAMPLE_STROBE(strobe), .DATA_READY_N(data_ready_n_n), .WORD_READY(ready),
    .WORD_DATA(word), .REF_WORD_DATA(ref_word), .SETTLED(settled),
    .CAL_OK(cal_ok), .OVERRUN(ovr));
  host_model i_host (.CLOCK(CLOCK), .DATA_READY_N(data_ready_n_n), .stall(stall),
    .flip_en(flip_en), .WORD_READY(ready), .phase(phase), .words(words));
  // ---------------------------------------------------------------
  // Checks.
  // ---------------------------------------------------------------
  task chk(input [63:0] name, input [23:0] e, input [23:0] g);
    begin
      n_checks = n_checks + 1;
      if (g !== e) begin
        miscompares = miscompares + 1;
        $display("unexpected %0s exp %h got %h", name, e, g);
      end
    end
  endtask
  task wait_words(input integer n);
    begin
      repeat (n) @(negedge data_ready_n_n);
      @(negedge CLOCK);
    end
  endtask
  task complete_run;
    begin
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask
  initial begin
    #200000;
    miscompares = miscompares + 1;
    complete_run;
  end
  initial begin
    rows[0] = 11'h04F;
    rows[1] = 11'h550;
    rows[2] = 11'h664;
    rows[3] = 11'h778;
    rows[4] = 11'h079;
    repeat (20) @(negedge CLOCK);
    chk("data_ready_n_n", 1, data_ready_n_n);
    chk("oe", 1, pin_oe);
    chk("ovr", 0, ovr);
    RST = 0;
    $display("test reset done");
    // A steady input cancels over both phases, whatever the gain.
    for (i = 0; i < 5; i = i + 1) begin
      {GAIN_SEL, SPAN_PCT} = rows[i][9:0];
      wait_words(3);
      chk("cal", rows[i][10], cal_ok);
      chk("word", 0, word);
      chk("ref", 0, ref_word);
    end
    $display("test table done");
    @(posedge exc_out);
    t0 = $time;
    @(negedge exc_out);
    chk("half", EH, (($time - t0) / 4));
    @(negedge data_ready_n_n);
    t0 = $time;
    @(negedge data_ready_n_n);
    chk("rate", WP, (($time - t0) / 4));
    $display("test timing done");
    @(negedge CLOCK);
    stall = 1;
    repeat (6 * WP) @(negedge CLOCK);
    chk("ovr", 1, ovr);
    chk("data_ready_n_n", 0, data_ready_n_n);
    stall = 0;
    repeat (8) @(negedge CLOCK);
    chk("data_ready_n_n", 1, data_ready_n_n);
    chk("ovr", 1, ovr);
    $display("test overrun done");
    EXT_EXC = 1;
    flip_en = 1;
    wait_words(1);
    chk("oe", 0, pin_oe);
    @(phase);
    @(negedge CLOCK);
    flip_en = 0;
    wait_words(3);
    chk("settled", 0, settled);
    wait_words(4);
    chk("settled", 1, settled);
    chk("exc", phase, exc_out);
    $display("test external done");
    AC_MODE = 0;
    repeat (4) @(negedge CLOCK);
    chk("exc", 0, exc_out);
    chk("strobe", 0, strobe);
    $display("test dc done");
    complete_run;
  end
endmodule
